// ### logic/erase_pkg.sv
// constants and types of the display erase sequencer
// assumes one 20 MHz clock; one character phase per clock, five phases a character
package erase_pkg;

  // ==========================================================
  // character timing
  localparam logic [2:0] PH_T1 = 3'h0;
  localparam logic [2:0] PH_T2 = 3'h1;
  localparam logic [2:0] PH_T4 = 3'h3;
  localparam logic [2:0] PH_T5 = 3'h4;
  localparam logic [6:0] CHAR_LAST_VISIBLE = 7'h4f; // character 79, count 80 follows
  localparam logic [6:0] CHAR_VISIBLE_END = 7'h50;  // count 80
  localparam logic [6:0] CHAR_LINE_LAST = 7'h63;    // character 99, count 100 follows
  localparam logic [2:0] LAST_ROW_COUNT = 3'h6;     // line six ends a clear

  // ==========================================================
  // function codes (ctrl-l, ctrl-k, ctrl-x)
  localparam logic [6:0] CODE_SCREEN = 7'h0c;
  localparam logic [6:0] CODE_PAGE = 7'h0b;
  localparam logic [6:0] CODE_ENTRY = 7'h18;

  // ==========================================================
  // register map and fields
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CURSOR = 8'h04;
  localparam logic [7:0] OFS_DELIM = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam int CTRL_SET_FORMS = 0;
  localparam int CTRL_RESET_FORMS = 1;
  localparam int POS_COL = 0;    // column field [6:0]
  localparam int POS_ROW = 8;    // row / line field [10:8]
  localparam int STAT_BUSY = 0;
  localparam int STAT_FORMS = 1;
  localparam int STAT_PEND = 2;
  localparam int STAT_VIDEO = 3;
  localparam int STAT_RUN = 4;   // running function [5:4]
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;

  typedef enum logic [1:0] {FN_NONE, FN_SCREEN, FN_PAGE, FN_ENTRY} fn_t;
  typedef enum logic [2:0] {S_IDLE, S_ARM, S_SCREEN, S_LINE, S_DONE} seq_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
  } ahb_req_t;

endpackage : erase_pkg

// ### logic/display_erase_sequencer.sv
// erase sequencer: full-screen clear, clear to end of page, clear entry
// assumes host and keyboard cycles come from logic on clk_sys, one cycle wide
//
// How it works
// RULE_01 - screen clear from host or ctrl-l
// RULE_02 - seven-bit code decoded, pulse at t4
// RULE_03 - screen clear homes row and column
// RULE_04 - video off during screen clear
// RULE_05 - screen clear returns to general format
// RULE_06 - zero data, write cycles from t5
// RULE_07 - shift enable t2 to t2 after correlation
// RULE_08 - count 80: next row, column zero
// RULE_09 - line end writes zero delineator at t4
// RULE_10 - row six ends screen clear, releases all
// RULE_11 - page clear from cursor, cursor stays
// RULE_12 - page clear from host or ctrl-k
// RULE_13 - line flag set, edit counter counts
// RULE_14 - wait count 100, then zero data
// RULE_15 - shift enable held until count 80
// RULE_16 - first line cursor column, then delineator
// RULE_17 - delineator reads zero or colon plus one
// RULE_18 - count 80: step row, select delineator
// RULE_19 - line six at t2 ends page clear
// RULE_20 - clear entry homes, keeps delineators
// RULE_21 - delineators kept until screen clear
// RULE_22 - clear entry from host or ctrl-x
// RULE_23 - one erase at a time, others held; the code holds only one, and a further code is dropped
//
// The register offsets and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/1ps
module display_erase_sequencer
  import erase_pkg::*;
#(
  parameter int LINES = 6
) (
  input wire logic clk_sys, // 20 MHz system clock
  input wire logic sys_rst, // async reset, active high
  input wire logic hsel, // ahb slave select
  input wire logic [7:0] haddr, // ahb byte address
  input wire logic [1:0] htrans, // ahb transfer type
  input wire logic hwrite, // ahb write
  input wire logic [2:0] hsize, // ahb size, word only
  input wire logic [31:0] hwdata, // ahb write data
  input wire logic hready, // ahb bus ready
  output logic hreadyout, // ahb slave ready
  output logic [31:0] hrdata, // ahb read data
  output logic hresp, // ahb response, always okay
  input wire logic host_receive_cycle, // code from host interface
  input wire logic keyboard_cycle, // code from keyboard
  input wire logic [6:0] function_code_bits, // parallel function code
  output logic screen_clear_decoded, // decoded screen clear pulse
  output logic page_end_clear_decoded, // decoded page or entry clear pulse
  output logic column_counter_reset, // cursor column reset pulse
  output logic row_counter_reset, // cursor row reset pulse
  output logic [6:0] cursor_col, // cursor column counter
  output logic [2:0] cursor_row, // cursor row counter
  output logic [2:0] row_edit, // row edit counter
  output logic screen_clear_active, // screen clear running
  output logic video_blank_n, // low while video is blanked
  output logic video_enable, // character video enable
  output logic forms_active, // split format set
  output logic general_format_n, // high in general format
  output logic shift_clock_enable, // memory shift clock enable
  output logic memory_phase_clock, // memory phase clock pulse
  output logic data_reg_zero, // data register forced to zero
  output logic mem_write, // memory write cycle pulse
  output logic line_end_pulse, // count 80 during screen clear
  output logic delim_mem_write, // delineator memory write pulse
  output logic [6:0] delim_mem_column, // delineator memory output column
  output logic line_clear_flag, // page or entry clear armed
  output logic count_hundred_pulse, // count 100 seen while armed
  output logic column_mux_select_delim, // column mux on delineator output
  output logic row_edit_increment, // edit row step pulse
  output logic last_row_detect, // row count reached six
  output logic clear_done // page or entry clear finished
);

  typedef struct packed {
    seq_t seq;
    fn_t pend;
    fn_t run;
    logic [2:0] phase;
    logic [6:0] chr;
    logic [6:0] ccol;
    logic [2:0] crow;
    logic [2:0] erow;
    logic [6:0] start;
    logic [LINES-1:0][6:0] delim;
    logic dwr_pend;
    logic [2:0] dwr_line;
    logic forms, video, lcf, zero, shen, phclk, mwr, mux_delim, scr, gfmt_n;
    logic dec_scr, dec_page, col_rst, row_rst, lend, dwr, c100, rinc, last, done;
    logic [6:0] dcol;
    ahb_req_t req;
    logic ready;
    logic [31:0] rdata;
  } state_t;

  state_t st_reg, st_next;
  fn_t code_fn;
  logic char_end;
  logic [6:0] dsel;

  always_comb begin
    unique case (function_code_bits)
      CODE_SCREEN: code_fn = FN_SCREEN;
      CODE_PAGE: code_fn = FN_PAGE;
      CODE_ENTRY: code_fn = FN_ENTRY;
      default: code_fn = FN_NONE;
    endcase
  end

  assign char_end = (st_reg.phase == PH_T5);

  always_comb begin
    st_next = st_reg;
    dsel = 7'h00;
    // ==========================================================
    // character phase and count
    st_next.phase = char_end ? PH_T1 : st_reg.phase + 3'h1;
    if (char_end) begin
      st_next.chr = (st_reg.chr == CHAR_LINE_LAST) ? 7'h00 : st_reg.chr + 7'h01;
    end
    // pulses default low
    st_next.dec_scr = 1'b0;
    st_next.dec_page = 1'b0;
    st_next.col_rst = 1'b0;
    st_next.row_rst = 1'b0;
    st_next.lend = 1'b0;
    st_next.dwr = 1'b0;
    st_next.c100 = 1'b0;
    st_next.rinc = 1'b0;
    st_next.done = 1'b0;
    st_next.mwr = 1'b0;
    st_next.phclk = 1'b0;

    // ==========================================================
    // code capture: a code seen while busy waits here
    if ((host_receive_cycle || keyboard_cycle) && st_reg.pend == FN_NONE) begin
      st_next.pend = code_fn; // [RULE_01] [RULE_12] [RULE_22] [RULE_23]
    end
    if (!st_reg.lcf) begin
      st_next.erow = st_reg.crow; // parallel load while not armed [RULE_13]
    end

    // ==========================================================
    // sequencer
    unique case (st_reg.seq)
      S_IDLE: begin
        if (st_reg.phase == PH_T4 && st_reg.pend != FN_NONE) begin // [RULE_02] [RULE_23]
          st_next.run = st_reg.pend;
          st_next.pend = FN_NONE;
          st_next.seq = S_ARM;
          if (st_reg.pend == FN_SCREEN) begin
            st_next.dec_scr = 1'b1;
            st_next.col_rst = 1'b1;
            st_next.row_rst = 1'b1;
            st_next.ccol = 7'h00; // [RULE_03]
            st_next.crow = 3'h0; // [RULE_03]
            st_next.video = 1'b0; // [RULE_04]
            st_next.forms = 1'b0; // [RULE_05]
            st_next.zero = 1'b1; // [RULE_06]
          end else begin
            st_next.dec_page = 1'b1;
            st_next.lcf = 1'b1; // [RULE_13]
            st_next.mux_delim = 1'b0;
            st_next.start = st_reg.ccol; // first line from cursor [RULE_11] [RULE_16]
            st_next.erow = st_reg.crow;
            if (st_reg.pend == FN_ENTRY) begin
              st_next.col_rst = 1'b1;
              st_next.row_rst = 1'b1;
              st_next.crow = 3'h0; // [RULE_20]
              st_next.erow = 3'h0;
              dsel = st_reg.forms ? st_reg.delim[0] + 7'h01 : 7'h00; // [RULE_20]
              st_next.ccol = dsel;
              st_next.start = dsel;
            end
          end
        end
      end
      S_ARM: begin
        if (char_end && st_reg.chr == CHAR_LINE_LAST) begin // count 100 [RULE_14]
          if (st_reg.run == FN_SCREEN) begin
            st_next.seq = S_SCREEN;
          end else begin
            st_next.c100 = 1'b1;
            st_next.zero = 1'b1; // [RULE_14]
            st_next.seq = S_LINE;
          end
        end
      end
      S_SCREEN: begin
        if (st_reg.phase == PH_T2) begin
          st_next.shen = (st_reg.chr < CHAR_VISIBLE_END); // [RULE_07]
        end
        if (char_end && st_reg.shen) begin
          st_next.mwr = 1'b1; // back-to-back writes of zero [RULE_06]
          st_next.ccol = st_reg.chr + 7'h01;
        end
        if (char_end && st_reg.chr == CHAR_LAST_VISIBLE) begin // [RULE_08]
          st_next.lend = 1'b1;
          st_next.col_rst = 1'b1;
          st_next.ccol = 7'h00;
          st_next.crow = st_reg.crow + 3'h1;
          st_next.dwr_pend = 1'b1;
          st_next.dwr_line = st_reg.crow;
          if (st_reg.crow + 3'h1 == LAST_ROW_COUNT) begin // [RULE_10]
            st_next.last = 1'b1;
            st_next.seq = S_IDLE;
            st_next.run = FN_NONE;
            st_next.zero = 1'b0;
            st_next.video = 1'b1;
            st_next.shen = 1'b0;
          end
        end
      end
      S_LINE: begin
        if (st_reg.phase == PH_T2) begin
          // correlation at the start column, held to count 80 [RULE_15]
          st_next.shen = (st_reg.chr >= st_reg.start) && (st_reg.chr < CHAR_VISIBLE_END);
        end
        if (char_end && st_reg.shen) begin
          st_next.mwr = 1'b1;
        end
        if (char_end && st_reg.chr == CHAR_LAST_VISIBLE) begin // [RULE_18]
          st_next.rinc = 1'b1;
          st_next.erow = st_reg.erow + 3'h1; // [RULE_13]
          st_next.mux_delim = 1'b1; // [RULE_16]
          st_next.zero = 1'b0;
          st_next.shen = 1'b0;
          if (st_reg.erow + 3'h1 >= LAST_ROW_COUNT) begin
            st_next.seq = S_DONE;
          end else begin
            if (st_reg.forms) begin
              dsel = st_reg.delim[st_reg.erow + 3'h1] + 7'h01; // [RULE_17]
            end
            st_next.start = dsel; // [RULE_16] [RULE_17]
            st_next.seq = S_ARM;
          end
        end
      end
      S_DONE: begin
        if (st_reg.phase == PH_T2) begin // [RULE_19]
          st_next.done = 1'b1;
          st_next.last = 1'b1;
          st_next.lcf = 1'b0;
          st_next.mux_delim = 1'b0;
          st_next.run = FN_NONE;
          st_next.seq = S_IDLE;
        end
      end
    endcase
    if (st_reg.seq != S_SCREEN && st_reg.seq != S_DONE) begin
      st_next.last = 1'b0;
    end
    st_next.phclk = st_reg.shen && st_reg.phase == PH_T4;
    st_next.dcol = st_next.start;

    // ==========================================================
    // delineator memory: cleared only by screen clear [RULE_21]
    if (st_reg.dwr_pend && st_reg.phase == PH_T4) begin
      st_next.dwr_pend = 1'b0;
      st_next.dwr = 1'b1;
      st_next.delim[st_reg.dwr_line] = 7'h00; // [RULE_09]
    end

    // ==========================================================
    // ahb-lite slave, zero wait states
    st_next.ready = 1'b1;
    if (st_reg.req.valid && st_reg.req.write) begin
      unique case (st_reg.req.addr)
        OFS_CTRL: begin
          if (hwdata[CTRL_SET_FORMS]) begin
            st_next.forms = 1'b1;
          end
          if (hwdata[CTRL_RESET_FORMS] && st_reg.run != FN_SCREEN) begin
            st_next.forms = 1'b0;
          end
        end
        OFS_CURSOR: begin
          if (st_reg.seq == S_IDLE) begin
            st_next.ccol = hwdata[POS_COL +: 7];
            st_next.crow = hwdata[POS_ROW +: 3];
          end
        end
        OFS_DELIM: begin
          // colons are written only in general format
          if (!st_reg.forms && st_reg.seq == S_IDLE && hwdata[POS_ROW +: 3] < LINES) begin
            st_next.delim[hwdata[POS_ROW +: 3]] = hwdata[POS_COL +: 7];
          end
        end
        default: begin
        end
      endcase
    end
    st_next.req.valid = hsel && hready && htrans == HTRANS_NONSEQ;
    st_next.req.write = hwrite;
    st_next.req.addr = haddr;
    st_next.rdata = 32'h0000_0000;
    if (hsel && hready && htrans == HTRANS_NONSEQ && !hwrite) begin
      unique case (haddr)
        OFS_CTRL: st_next.rdata[CTRL_SET_FORMS] = st_reg.forms;
        OFS_CURSOR: begin
          st_next.rdata[POS_COL +: 7] = st_reg.ccol;
          st_next.rdata[POS_ROW +: 3] = st_reg.crow;
        end
        OFS_STATUS: begin
          st_next.rdata[STAT_BUSY] = st_reg.seq != S_IDLE;
          st_next.rdata[STAT_FORMS] = st_reg.forms;
          st_next.rdata[STAT_PEND] = st_reg.pend != FN_NONE;
          st_next.rdata[STAT_VIDEO] = st_reg.video;
          st_next.rdata[STAT_RUN +: 2] = st_reg.run;
        end
        default: st_next.rdata = 32'h0000_0000;
      endcase
    end
    st_next.scr = (st_next.run == FN_SCREEN);
    st_next.gfmt_n = !st_next.forms;
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg <= '0;
      st_reg.video <= 1'b1;
      st_reg.gfmt_n <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // outputs, all but hresp straight from the state register; hresp is tied to HRESP_OKAY
  assign hreadyout = st_reg.ready;
  assign hrdata = st_reg.rdata;
  assign hresp = HRESP_OKAY;
  assign screen_clear_decoded = st_reg.dec_scr;
  assign page_end_clear_decoded = st_reg.dec_page;
  assign column_counter_reset = st_reg.col_rst;
  assign row_counter_reset = st_reg.row_rst;
  assign cursor_col = st_reg.ccol;
  assign cursor_row = st_reg.crow;
  assign row_edit = st_reg.erow;
  assign screen_clear_active = st_reg.scr;
  assign video_blank_n = st_reg.video;
  assign video_enable = st_reg.video;
  assign forms_active = st_reg.forms;
  assign general_format_n = st_reg.gfmt_n;
  assign shift_clock_enable = st_reg.shen;
  assign memory_phase_clock = st_reg.phclk;
  assign data_reg_zero = st_reg.zero;
  assign mem_write = st_reg.mwr;
  assign line_end_pulse = st_reg.lend;
  assign delim_mem_write = st_reg.dwr;
  assign delim_mem_column = st_reg.dcol;
  assign line_clear_flag = st_reg.lcf;
  assign count_hundred_pulse = st_reg.c100;
  assign column_mux_select_delim = st_reg.mux_delim;
  assign row_edit_increment = st_reg.rinc;
  assign last_row_detect = st_reg.last;
  assign clear_done = st_reg.done;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  chk_decode_at_t4: assert property ( // [RULE_02]
    (screen_clear_decoded || page_end_clear_decoded) |-> $past(st_reg.phase) == PH_T4)
    else $error("decode pulse not at t4");
  chk_screen_home: assert property ( // [RULE_03]
    screen_clear_decoded |-> cursor_col == 7'h00 && cursor_row == 3'h0 && !forms_active)
    else $error("screen clear did not home or reset format");
  chk_video_blank: assert property ( // [RULE_04]
    screen_clear_active |-> !video_enable) else $error("video on during screen clear");
  chk_zero_writes: assert property ( // [RULE_06]
    mem_write |-> $past(data_reg_zero) && $past(st_reg.phase) == PH_T5)
    else $error("write without zero data or off t5");
  chk_shift_start: assert property ( // [RULE_07]
    $rose(shift_clock_enable) |-> $past(st_reg.phase) == PH_T2)
    else $error("shift enable started off t2");
  chk_line_end_delim: assert property ( // [RULE_09]
    line_end_pulse |-> ##[1:5] delim_mem_write) else $error("no delineator write at line end");
  chk_screen_end: assert property ( // [RULE_10]
    (line_end_pulse && cursor_row == LAST_ROW_COUNT) |-> !data_reg_zero && video_enable)
    else $error("screen clear did not release at row six");
  chk_page_cursor: assert property ( // [RULE_11]
    (line_clear_flag && $past(line_clear_flag) && st_reg.seq != S_IDLE) |->
      cursor_col == $past(cursor_col)) else $error("cursor moved during page clear");
  chk_row_step: assert property ( // [RULE_18]
    row_edit_increment |-> row_edit == $past(row_edit) + 3'h1 && column_mux_select_delim)
    else $error("row edit step wrong");
  chk_done_t2: assert property ( // [RULE_19]
    clear_done |-> $past(st_reg.phase) == PH_T2 && !line_clear_flag && !column_mux_select_delim)
    else $error("page clear end wrong");
  chk_code_held: assert property ( // [RULE_23]
    (st_reg.pend != FN_NONE && st_reg.seq != S_IDLE) |=> st_reg.pend == $past(st_reg.pend))
    else $error("held code lost");
  cov_screen: cover property (line_end_pulse && last_row_detect);
  cov_page: cover property (row_edit_increment ##[1:8] clear_done);
  cov_entry_split: cover property (page_end_clear_decoded && forms_active && cursor_row == 3'h0);
  cov_held: cover property (st_reg.pend != FN_NONE && st_reg.seq != S_IDLE);
endmodule : display_erase_sequencer

// ### testbench/code_source.sv
// code source model: host receive cycles and keyboard cycles
// assumes the bench calls send just after a rising edge of clk_sys
`timescale 1ns/1ps
module code_source (
  input wire logic clk_sys, // system clock
  output logic host_receive_cycle, // host code strobe
  output logic keyboard_cycle, // keyboard code strobe
  output logic [6:0] function_code_bits // parallel code
);
  initial begin
    host_receive_cycle = 1'b0;
    keyboard_cycle = 1'b0;
    function_code_bits = 7'h00;
  end

  // ==========================================================
  // one strobe a code; bits scrambled outside the strobe
  task send(input logic [6:0] c, input logic kb);
    function_code_bits <= c;
    keyboard_cycle <= kb;
    host_receive_cycle <= !kb;
    @(posedge clk_sys);
    #1;
    keyboard_cycle <= 1'b0;
    host_receive_cycle <= 1'b0;
    function_code_bits <= ~c;
  endtask : send
endmodule : code_source

// ### testbench/display_erase_sequencer_tb_top.sv
// bench of the display erase sequencer: ahb master, code source, counters
// assumes one 50 ns clock; counters sample design outputs at each rising edge
`timescale 1ns/1ps
module display_erase_sequencer_tb_top
  import erase_pkg::*;
;
  logic clk_sys, sys_rst, hsel, hwrite, hready, hreadyout, hresp;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize, cursor_row, row_edit;
  logic [31:0] hwdata, hrdata, d;
  logic [31:0] rd_q = 32'h0;
  logic rdy_q = 1'b0;
  logic host_receive_cycle, keyboard_cycle;
  logic [6:0] function_code_bits, cursor_col, delim_mem_column;
  logic screen_clear_decoded, page_end_clear_decoded, column_counter_reset, row_counter_reset;
  logic screen_clear_active, video_blank_n, video_enable, forms_active, general_format_n;
  logic shift_clock_enable, memory_phase_clock, data_reg_zero, mem_write, line_end_pulse;
  logic delim_mem_write, line_clear_flag, count_hundred_pulse, column_mux_select_delim;
  logic row_edit_increment, last_row_detect, clear_done;
  int n_wr = 0, n_le = 0, n_dw = 0, n_ri = 0, n_hund = 0, n_sd = 0, n_pd = 0;
  int n_end = 0, n_vid = 0, cyc = 0, failures = 0, cmp_count = 0;
  int n_ph = 0, n_lr = 0, n_rr = 0;
  int r, c, ri0, h0, le0, dw0, s0, p0, rr0;
  int dl[6];
  logic [31:0] seed = 32'h29417152;

  display_erase_sequencer #(.LINES(6)) dut_u (.*);
  code_source src_u (.*);
  assign hready = hreadyout;

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // ==========================================================
  // counters of design pulses, sampled before each edge lands
  always @(posedge clk_sys) begin
    rd_q <= hrdata;
    rdy_q <= hreadyout;
    cyc <= cyc + 1;
    n_wr <= n_wr + int'(mem_write === 1'b1);
    n_le <= n_le + int'(line_end_pulse === 1'b1);
    n_dw <= n_dw + int'(delim_mem_write === 1'b1);
    n_ri <= n_ri + int'(row_edit_increment === 1'b1);
    n_hund <= n_hund + int'(count_hundred_pulse === 1'b1);
    n_sd <= n_sd + int'(screen_clear_decoded === 1'b1);
    n_pd <= n_pd + int'(page_end_clear_decoded === 1'b1);
    n_end <= n_end + int'(clear_done === 1'b1 || $fell(screen_clear_active));
    n_vid <= n_vid + int'(screen_clear_active === 1'b1 &&
      (video_enable !== 1'b0 || video_blank_n !== 1'b0));
    n_ph <= n_ph + int'(memory_phase_clock === 1'b1);
    n_lr <= n_lr + int'(last_row_detect === 1'b1);
    n_rr <= n_rr + int'(row_counter_reset === 1'b1);
    if (cyc == 60000) begin
      failures++;
      print_verdict();
    end
  end

  // ==========================================================
  // helpers
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : rnd

  // writes of a clear from (col,row); later lines start past the colon when split
  function automatic int exp_writes(input int col, input int row, input bit split);
    int n;
    n = 80 - col;
    for (int l = row + 1; l < 6; l++) n += split ? 79 - dl[l] : 80;
    return n;
  endfunction : exp_writes

  task check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task print_verdict();
    $display("comparisons=%0d mismatches=%0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict

  task tick();
    @(posedge clk_sys);
    #1;
  endtask : tick

  task ahb_req(input logic [7:0] a, input logic wr, input logic [31:0] wd,
      output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= HTRANS_NONSEQ;
    do tick(); while (rdy_q !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do tick(); while (rdy_q !== 1'b1);
    rd = rd_q;
    check(hresp, HRESP_OKAY);
  endtask : ahb_req

  // send a code to an idle sequencer and see exactly one decode
  task run_fn(input logic [6:0] code, input logic kb);
    s0 = n_sd;
    p0 = n_pd;
    rr0 = n_rr;
    src_u.send(code, kb);
    for (int i = 0; i < 20 && n_sd == s0 && n_pd == p0; i++) tick();
    check(n_sd - s0, code == CODE_SCREEN);
    check(n_pd - p0, code != CODE_SCREEN);
    check(n_rr - rr0, code != CODE_PAGE);
  endtask : run_fn

  task wait_end(input int exp_w);
    int w0, e0, f0, l0;
    w0 = n_wr;
    e0 = n_end;
    f0 = n_ph;
    l0 = n_lr;
    for (int i = 0; i < 5000 && n_end == e0; i++) tick();
    check(n_end - e0, 1);
    check(n_wr - w0, exp_w);
    check(n_ph - f0, exp_w);
    check(n_lr - l0, 1);
    check(data_reg_zero, 1'b0);
  endtask : wait_end

  // ==========================================================
  // main sequence
  initial begin
    sys_rst = 1'b1;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (6) @(posedge clk_sys);
    #1;
    sys_rst <= 1'b0;
    ahb_req(OFS_STATUS, 1'b0, 32'h0, d);
    check(d, 32'h8);
    ahb_req(8'h10, 1'b1, 32'hffffffff, d);
    ahb_req(8'h10, 1'b0, 32'h0, d);
    check(d, 32'h0);
    ahb_req(OFS_CURSOR, 1'b1, 32'h0325, d);
    ahb_req(OFS_CTRL, 1'b1, 32'h1, d);
    check(forms_active, 1'b1);
    // screen clear from the keyboard while split and cursor away from home
    run_fn(CODE_SCREEN, 1'b1);
    tick();
    tick();
    check(cursor_col, 7'h00);
    check(cursor_row, 3'h0);
    check(forms_active, 1'b0);
    le0 = n_le;
    dw0 = n_dw;
    wait_end(exp_writes(0, 0, 1'b0));
    check(n_le - le0, 6);
    // last delineator write lands at the t4 after the final line end
    repeat (6) tick();
    check(n_dw - dw0, 6);
    check(n_vid, 0);
    check(video_enable, 1'b1);
    check(video_blank_n, 1'b1);
    // colons per line, line 0 at the widest legal column
    for (int l = 0; l < 6; l++) begin
      dl[l] = (l == 0) ? 77 : rnd() % 78;
      ahb_req(OFS_DELIM, 1'b1, (l << 8) | dl[l], d);
    end
    ahb_req(OFS_CTRL, 1'b1, 32'h1, d);
    r = rnd() % 6;
    c = dl[r] + 1 + rnd() % (79 - dl[r]);
    ahb_req(OFS_CURSOR, 1'b1, (r << 8) | c, d);
    ahb_req(OFS_CURSOR, 1'b0, 32'h0, d);
    check(d, (r << 8) | c);
    // split page clear from the host; entry queued behind it, screen dropped
    run_fn(CODE_PAGE, 1'b0);
    check(line_clear_flag, 1'b1);
    ri0 = n_ri;
    h0 = n_hund;
    src_u.send(CODE_ENTRY, 1'b1);
    tick();
    src_u.send(CODE_SCREEN, 1'b0);
    ahb_req(OFS_STATUS, 1'b0, 32'h0, d);
    check(d[STAT_PEND], 1'b1);
    wait_end(exp_writes(c, r, 1'b1));
    check(cursor_col, c);
    check(cursor_row, r);
    check(n_ri - ri0, 6 - r);
    check(n_hund - h0, 6 - r);
    wait_end(exp_writes(dl[0] + 1, 0, 1'b1));
    check(cursor_row, 3'h0);
    check(cursor_col, dl[0] + 1);
    check(delim_mem_column, dl[5] + 1);
    check(n_pd - p0, 2);
    check(n_sd - s0, 0);
    check(forms_active, 1'b1);
    // general format: page clear from the keyboard, entry from the host
    ahb_req(OFS_CTRL, 1'b1, 32'h2, d);
    check(general_format_n, 1'b1);
    r = rnd() % 6;
    c = rnd() % 80;
    ahb_req(OFS_CURSOR, 1'b1, (r << 8) | c, d);
    run_fn(CODE_PAGE, 1'b1);
    wait_end(exp_writes(c, r, 1'b0));
    check(cursor_col, c);
    run_fn(CODE_ENTRY, 1'b0);
    wait_end(exp_writes(0, 0, 1'b0));
    check(cursor_col, 7'h00);
    check(cursor_row, 3'h0);
    check(delim_mem_column, 7'h00);
    print_verdict();
  end
endmodule : display_erase_sequencer_tb_top
